//--- hdl/power_controller.sv
// Power-mode and power-domain controller, device end
`timescale 1ns/10ps
`include "power_ctrl_defines.svh"
module power_controller (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link to core software
    power_link_if.device link,
    // Power switch outputs
    output logic always_on_domain,
    output logic system_domain,
    output logic peripheral_domain,
    output logic debug_domain,
    output logic radio_domain,
    output logic [3:0] retention_ram_domains,
    output logic sysram_retention_domain,
    output logic analog_enable,
    // Core and memory control
    output logic core_reset,
    output logic boot_from_sysram,
    output logic sysram_access_enable,
    output logic mirror_write,
    output logic [7:0] mirror_addr
);
    power_ctrl_pkg::mode_t mode;
    power_ctrl_pkg::mode_t next_mode;
    logic retained;
    logic next_retained;
    logic remap;
    logic next_remap;
    logic [7:0] settle;
    logic [7:0] next_settle;
    logic [3:0] rst_count;
    logic [3:0] next_rst_count;
    logic mirror_start;
    logic mirror_busy;
    logic mirror_done;
    logic mirror_copy;
    logic [7:0] mirror_word;

    // Gated sleep decode, shared by every switch that the sequencer turns off
    function automatic logic mode_is_gated(input power_ctrl_pkg::mode_t m);
        return m == power_ctrl_pkg::MODE_GATED;
    endfunction

    // Copier used on wake from deep sleep
    mirror_engine copier (
        .clk(clk),
        .reset(reset),
        .start(mirror_start),
        .busy(mirror_busy),
        .done(mirror_done),
        .copy_write(mirror_copy),
        .copy_addr(mirror_word)
    );

    // Mode sequencing
    always_comb begin
        next_mode = mode;
        next_retained = retained;
        next_remap = remap;
        next_settle = settle;
        next_rst_count = rst_count;
        mirror_start = 1'b0;
        // Remap is sticky: only a hardware reset clears it, so a reboot keeps it
        if (link.address_zero_remap) begin
            next_remap = 1'b1;
        end
        unique case (mode)
            power_ctrl_pkg::MODE_ACTIVE: begin
                if (link.soft_reset_request) begin
                    next_mode = power_ctrl_pkg::MODE_REBOOT;
                    next_rst_count = `RESET_CYCLES;
                end else if (link.sleep_request && link.deep_sleep_request) begin
                    // Retain select picks extended over deep
                    next_retained = link.sysram_retain_select;
                    next_mode = power_ctrl_pkg::MODE_GATED;
                end else if (link.sleep_request) begin
                    next_mode = power_ctrl_pkg::MODE_IDLE;
                end
            end
            power_ctrl_pkg::MODE_IDLE: begin
                if (link.wake_event) begin
                    next_mode = power_ctrl_pkg::MODE_ACTIVE;
                end
            end
            power_ctrl_pkg::MODE_GATED: begin
                // Only a wake leaves gated sleep; commands are dropped here
                if (link.wake_event) begin
                    next_mode = power_ctrl_pkg::MODE_POWER_UP;
                    next_settle = `SETTLE_CYCLES;
                end
            end
            power_ctrl_pkg::MODE_POWER_UP: begin
                // Rails and analog settle while the core is still held in reset
                if (settle != 8'h00) begin
                    next_settle = settle - 8'h01;
                end else if (retained) begin
                    next_mode = power_ctrl_pkg::MODE_ACTIVE;
                end else begin
                    mirror_start = 1'b1;
                    next_mode = power_ctrl_pkg::MODE_MIRROR;
                end
            end
            power_ctrl_pkg::MODE_MIRROR: begin
                // Leave only once the copier has written its last word and gone idle
                if (mirror_done && !mirror_busy) begin
                    next_mode = power_ctrl_pkg::MODE_ACTIVE;
                    next_retained = 1'b1;
                end
            end
            power_ctrl_pkg::MODE_REBOOT: begin
                // Hold the core in reset for a fixed count; remap is left alone
                if (rst_count != 4'h0) begin
                    next_rst_count = rst_count - 4'h1;
                end else begin
                    next_mode = power_ctrl_pkg::MODE_ACTIVE;
                end
            end
            default: begin
                next_mode = power_ctrl_pkg::MODE_ACTIVE;
            end
        endcase
    end

    // Register sequencing state; remap survives software reboot
    always_ff @(posedge clk) begin
        if (reset) begin
            mode <= power_ctrl_pkg::MODE_ACTIVE;
            retained <= 1'b1;
            remap <= 1'b0;
            settle <= 8'h00;
            rst_count <= 4'h0;
        end else begin
            mode <= next_mode;
            retained <= next_retained;
            remap <= next_remap;
            settle <= next_settle;
            rst_count <= next_rst_count;
        end
    end

    // Registered power switch and status outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            always_on_domain <= 1'b1;
            system_domain <= 1'b1;
            peripheral_domain <= 1'b1;
            debug_domain <= 1'b1;
            radio_domain <= 1'b1;
            retention_ram_domains <= 4'h0;
            sysram_retention_domain <= 1'b1;
            analog_enable <= 1'b1;
            core_reset <= 1'b0;
            boot_from_sysram <= 1'b0;
            sysram_access_enable <= 1'b1;
            mirror_write <= 1'b0;
            mirror_addr <= 8'h00;
            link.core_running <= 1'b1;
            link.mode <= 3'h0;
            link.sysram_valid <= 1'b1;
        end else begin
            always_on_domain <= 1'b1;
            // System and debug off only while gated
            system_domain <= !mode_is_gated(next_mode);
            debug_domain <= !mode_is_gated(next_mode);
            // Software-chosen domains, untouched by the sequencer
            peripheral_domain <= link.peripheral_domain_select;
            radio_domain <= link.radio_domain_select;
            retention_ram_domains <= link.retention_ram_domains;
            // Sysram kept on except in deep sleep
            sysram_retention_domain <= !mode_is_gated(next_mode) || next_retained;
            analog_enable <= !mode_is_gated(next_mode);
            core_reset <= (next_mode == power_ctrl_pkg::MODE_REBOOT)
                || (next_mode == power_ctrl_pkg::MODE_POWER_UP)
                || (next_mode == power_ctrl_pkg::MODE_MIRROR);
            boot_from_sysram <= next_remap;
            // No access while only the retention domain holds sysram
            sysram_access_enable <= !mode_is_gated(next_mode)
                && (next_mode != power_ctrl_pkg::MODE_POWER_UP);
            mirror_write <= mirror_copy;
            mirror_addr <= mirror_word;
            link.core_running <= (next_mode == power_ctrl_pkg::MODE_ACTIVE);
            link.mode <= next_mode;
            link.sysram_valid <= next_retained;
        end
    end

endmodule

//--- hdl/power_ctrl_defines.svh
// Constants of the power-mode controller
`ifndef POWER_CTRL_DEFINES_SVH
`define POWER_CTRL_DEFINES_SVH
`define ADDR_W 4
`define DATA_W 16
// Software register offsets
`define REG_CONTROL 4'h0
`define REG_DOMAINS 4'h1
`define REG_STATUS 4'h2
`define REG_COMMAND 4'h3
// Control register fields
`define CTL_RETAIN_BIT 0
`define CTL_REMAP_BIT 1
// Domain register fields
`define DOM_PERIPH_BIT 0
`define DOM_RADIO_BIT 1
`define DOM_RR_LSB 2
`define DOM_RR_W 4
// Command register fields
`define CMD_SLEEP_BIT 0
`define CMD_DEEP_BIT 1
`define CMD_SWRESET_BIT 2
`define CMD_WAKE_BIT 3
// Reset values
`define DOM_RESET 16'h0003
`define CTL_RESET 16'h0000
// Timing counts
`define SETTLE_CYCLES 8'h10
`define COPY_WORDS 8'h20
`define RESET_CYCLES 4'h4
`endif

//--- hdl/power_ctrl_pkg.sv
// Types of the power-mode link, used by the controller end and the checks
package power_ctrl_pkg;
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'h0,
        MODE_IDLE = 3'h1,
        MODE_GATED = 3'h3,
        MODE_POWER_UP = 3'h2,
        MODE_MIRROR = 3'h6,
        MODE_REBOOT = 3'h7
    } mode_t;
    typedef enum logic [1:0] {
        SLEEP_NONE = 2'h0,
        SLEEP_PLAIN = 2'h1,
        SLEEP_EXTENDED = 2'h2,
        SLEEP_DEEP = 2'h3
    } sleep_kind_t;
endpackage

//--- hdl/power_link_if.sv
// Link between the core-software side and the power controller
`timescale 1ns/10ps
interface power_link_if;
    logic sleep_request;
    logic deep_sleep_request;
    logic sysram_retain_select;
    logic address_zero_remap;
    logic soft_reset_request;
    logic [3:0] retention_ram_domains;
    logic peripheral_domain_select;
    logic radio_domain_select;
    logic wake_event;
    logic core_running;
    logic [2:0] mode;
    logic sysram_valid;
    modport device (
        input sleep_request, deep_sleep_request, sysram_retain_select,
        input address_zero_remap, soft_reset_request, retention_ram_domains,
        input peripheral_domain_select, radio_domain_select, wake_event,
        output core_running, mode, sysram_valid
    );
    modport host (
        output sleep_request, deep_sleep_request, sysram_retain_select,
        output address_zero_remap, soft_reset_request, retention_ram_domains,
        output peripheral_domain_select, radio_domain_select, wake_event,
        input core_running, mode, sysram_valid
    );
endinterface

//--- hdl/mirror_engine.sv
// Hardware copier that refills system RAM from program memory
`timescale 1ns/10ps
`include "power_ctrl_defines.svh"
module mirror_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic start,
    output logic busy,
    output logic done,
    // Copy port
    output logic copy_write,
    output logic [7:0] copy_addr
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic next_busy;
    logic next_done;

    // Word counter: one word each cycle while busy
    always_comb begin
        next_count = count;
        next_busy = busy;
        next_done = 1'b0;
        if (start && !busy) begin
            next_busy = 1'b1;
            next_count = 8'h00;
        end else if (busy) begin
            if (count == `COPY_WORDS - 8'h01) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count + 8'h01;
            end
        end
    end

    // Register the copier state
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign copy_write = busy;
    assign copy_addr = count;
endmodule

//--- hdl/sleep_requester.sv
// Core-software end: turns register writes into sleep requests
`timescale 1ns/10ps
`include "power_ctrl_defines.svh"
module sleep_requester (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Software register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic write,
    input wire logic read,
    output logic [15:0] rdata,
    // Wake source
    input wire logic wake_in,
    // Link to controller
    power_link_if.host link
);
    logic [15:0] ctl;
    logic [15:0] dom;
    logic [15:0] next_ctl;
    logic [15:0] next_dom;
    logic [15:0] next_rdata;
    logic [3:0] cmd;
    logic [3:0] next_cmd;

    // Register writes and read mux
    always_comb begin
        next_ctl = ctl;
        next_dom = dom;
        next_cmd = 4'h0;
        next_rdata = 16'h0000;
        if (write) begin
            unique case (addr)
                `REG_CONTROL: next_ctl = {14'h0000, wdata[1:0]};
                `REG_DOMAINS: next_dom = {10'h000, wdata[5:0]};
                `REG_COMMAND: next_cmd = wdata[3:0];
                default: next_cmd = 4'h0;
            endcase
        end
        if (read) begin
            unique case (addr)
                `REG_CONTROL: next_rdata = ctl;
                `REG_DOMAINS: next_rdata = dom;
                `REG_STATUS: next_rdata = {11'h000, link.sysram_valid,
                    link.core_running, link.mode};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // Register software state; commands are one-cycle pulses
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl <= `CTL_RESET;
            dom <= `DOM_RESET;
            cmd <= 4'h0;
            rdata <= 16'h0000;
        end else begin
            ctl <= next_ctl;
            dom <= next_dom;
            cmd <= next_cmd;
            rdata <= next_rdata;
        end
    end

    // Drive the link from software state
    assign link.sysram_retain_select = ctl[`CTL_RETAIN_BIT];
    assign link.address_zero_remap = ctl[`CTL_REMAP_BIT];
    assign link.sleep_request = cmd[`CMD_SLEEP_BIT];
    assign link.deep_sleep_request = cmd[`CMD_DEEP_BIT];
    assign link.soft_reset_request = cmd[`CMD_SWRESET_BIT];
    assign link.wake_event = cmd[`CMD_WAKE_BIT] | wake_in;
    assign link.peripheral_domain_select = dom[`DOM_PERIPH_BIT];
    assign link.radio_domain_select = dom[`DOM_RADIO_BIT];
    assign link.retention_ram_domains = dom[`DOM_RR_LSB +: `DOM_RR_W];
endmodule

//--- verif/sleep_power_domain_control_monitor.sv
// Concurrent checks on the link between the sleep requester and the power controller
`timescale 1ns/10ps
module sleep_power_domain_control_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Requests from the software end
    input wire logic sleep_request,
    input wire logic deep_sleep_request,
    input wire logic sysram_retain_select,
    input wire logic address_zero_remap,
    input wire logic soft_reset_request,
    input wire logic wake_event,
    // State from the controller end
    input wire logic core_running,
    input wire logic [2:0] mode,
    input wire logic sysram_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Steps of a gated sleep round trip
    sequence s_gate_req;
        sleep_request && deep_sleep_request && mode == power_ctrl_pkg::MODE_ACTIVE;
    endsequence
    sequence s_wake;
        mode == power_ctrl_pkg::MODE_GATED && wake_event;
    endsequence
    sequence s_mirror_start;
        mode == power_ctrl_pkg::MODE_MIRROR && $past(mode) != power_ctrl_pkg::MODE_MIRROR;
    endsequence
    // Entry, hold and exit of the sleep modes, and the software reboot
    AST_GATED_ENTRY: assert property (s_gate_req |=> mode == power_ctrl_pkg::MODE_GATED)
        else $error("Gated sleep not entered after request");
    AST_PLAIN_ENTRY: assert property (sleep_request && !deep_sleep_request &&
        mode == power_ctrl_pkg::MODE_ACTIVE |=> mode == power_ctrl_pkg::MODE_IDLE)
        else $error("Plain sleep not entered after request");
    AST_DEEP_LOSES_RAM: assert property (s_gate_req ##0 !sysram_retain_select
        |=> !sysram_valid)
        else $error("System RAM still valid in deep sleep");
    AST_EXT_KEEPS_RAM: assert property (s_gate_req ##0 sysram_retain_select
        |=> sysram_valid)
        else $error("System RAM lost in extended sleep");
    AST_GATED_HOLDS: assert property (mode == power_ctrl_pkg::MODE_GATED && !wake_event
        |=> mode == power_ctrl_pkg::MODE_GATED)
        else $error("Gated sleep left without a wake");
    AST_CORE_STOPPED: assert property (mode != power_ctrl_pkg::MODE_ACTIVE
        |-> !core_running)
        else $error("Core running outside active mode");
    AST_WAKE_POWER_UP: assert property (s_wake
        |=> (mode == power_ctrl_pkg::MODE_POWER_UP)[*8])
        else $error("Wake did not hold power-up");
    AST_MIRROR_FINISH: assert property (s_mirror_start |->
        (mode == power_ctrl_pkg::MODE_MIRROR)[*8]
        ##[1:40] (mode == power_ctrl_pkg::MODE_ACTIVE && sysram_valid))
        else $error("Mirror copy did not finish into active");
    AST_REBOOT: assert property (soft_reset_request
        && mode == power_ctrl_pkg::MODE_ACTIVE |=>
        (mode == power_ctrl_pkg::MODE_REBOOT && $stable(address_zero_remap))[*3]
        ##[1:10] mode == power_ctrl_pkg::MODE_ACTIVE)
        else $error("Software reset did not reboot the core");
endmodule

//--- verif/test_sleep_power_domain_control.sv
// Self-checking bench joining the sleep requester and the power controller
`timescale 1ns/10ps
`include "power_ctrl_defines.svh"
module test_sleep_power_domain_control;
    logic clk = 1'b0;
    logic reset, write, read, wake_in;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic always_on_domain, system_domain, peripheral_domain, debug_domain, radio_domain;
    logic [3:0] retention_ram_domains;
    logic sysram_retention_domain, analog_enable, core_reset, boot_from_sysram;
    logic sysram_access_enable, mirror_write;
    logic [7:0] mirror_addr;
    int fail_count = 0;
    int cmp_count = 0;
    power_link_if i_power_link_if ();
    sleep_requester i_sleep_requester (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .write(write), .read(read), .rdata(rdata), .wake_in(wake_in), .link(i_power_link_if.host));
    power_controller i_power_controller (.clk(clk), .reset(reset), .link(i_power_link_if.device),
        .always_on_domain(always_on_domain), .system_domain(system_domain),
        .peripheral_domain(peripheral_domain), .debug_domain(debug_domain),
        .radio_domain(radio_domain), .retention_ram_domains(retention_ram_domains),
        .sysram_retention_domain(sysram_retention_domain), .analog_enable(analog_enable),
        .core_reset(core_reset), .boot_from_sysram(boot_from_sysram),
        .sysram_access_enable(sysram_access_enable), .mirror_write(mirror_write),
        .mirror_addr(mirror_addr));
    sleep_power_domain_control_monitor i_monitor (.clk(clk), .reset(reset),
        .sleep_request(i_power_link_if.sleep_request),
        .deep_sleep_request(i_power_link_if.deep_sleep_request),
        .sysram_retain_select(i_power_link_if.sysram_retain_select),
        .address_zero_remap(i_power_link_if.address_zero_remap),
        .soft_reset_request(i_power_link_if.soft_reset_request),
        .wake_event(i_power_link_if.wake_event), .core_running(i_power_link_if.core_running),
        .mode(i_power_link_if.mode), .sysram_valid(i_power_link_if.sysram_valid));
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Comparison of one flag
    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Comparison of a word
    task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Comparison of the link mode
    task automatic chk_mode(input power_ctrl_pkg::mode_t exp);
        cmp_count++;
        if (i_power_link_if.mode !== exp) begin
            fail_count++;
            $display("[FAIL] mode expected %0d seen %0d", exp, i_power_link_if.mode);
        end
    endtask
    // Packs the switch outputs, access enable in bit 0
    task automatic chk_dom(input logic [15:0] exp);
        chk_vec("domains", exp, {4'h0, always_on_domain, system_domain, peripheral_domain,
            debug_domain, radio_domain, retention_ram_domains, sysram_retention_domain,
            analog_enable, sysram_access_enable});
    endtask
    // One-cycle register write and read
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clk);
        write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        read <= 1'b1;
        @(posedge clk);
        read <= 1'b0;
        #1 d = rdata;
    endtask
    // Lets the second edge after a write land
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Waits for active, counting copy strobes and core reset cycles
    task automatic wait_active(output int n_copy, output int n_hold, output logic [7:0] last);
        n_copy = 0;
        n_hold = 0;
        last = 8'h00;
        for (int i = 0; i < 400; i++) begin
            step();
            if (mirror_write === 1'b1) begin
                n_copy++;
                last = mirror_addr;
            end
            if (core_reset === 1'b1) n_hold++;
            if (i_power_link_if.mode === power_ctrl_pkg::MODE_ACTIVE) return;
        end
        fail_count++;
        $display("[FAIL] wait for active mode ran out");
        end_of_test();
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        logic [15:0] d;
        int n_copy;
        int n_hold;
        logic [7:0] last;
        reset = 1'b1;
        write = 1'b0;
        read = 1'b0;
        wake_in = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        // Reset state, defaults and an unmapped place
        step();
        chk_dom(16'h0f87);
        rd(`REG_DOMAINS, d);
        chk_vec("domain register", 16'h0003, d);
        wr(4'hf, 16'hffff);
        rd(4'hf, d);
        chk_vec("unmapped read", 16'h0000, d);
        rd(`REG_STATUS, d);
        chk_vec("status active", 16'h0018, d);
        // Plain sleep leaves every domain as it was in active and never holds the core
        wr(`REG_COMMAND, 16'h0001);
        step();
        chk_mode(power_ctrl_pkg::MODE_IDLE);
        chk_dom(16'h0f87);
        wr(`REG_COMMAND, 16'h0008);
        wait_active(n_copy, n_hold, last);
        chk_vec("core held after plain sleep", 16'h0000, 16'(n_hold));
        // Peripheral off, radio and banks 0 and 2 kept, then extended sleep
        wr(`REG_DOMAINS, 16'h0016);
        step();
        chk_dom(16'h0daf);
        wr(`REG_CONTROL, 16'h0001);
        wr(`REG_COMMAND, 16'h0003);
        step();
        chk_mode(power_ctrl_pkg::MODE_GATED);
        chk_dom(16'h08ac);
        rd(`REG_STATUS, d);
        chk_vec("status extended", 16'h0013, d);
        wr(`REG_COMMAND, 16'h0008);
        wait_active(n_copy, n_hold, last);
        chk_vec("copies after extended", 16'h0000, 16'(n_copy));
        chk_vec("core held on wake", {8'h00, `SETTLE_CYCLES} + 16'h0001, 16'(n_hold));
        chk_bit("sysram valid", 1'b1, i_power_link_if.sysram_valid);
        chk_dom(16'h0daf);
        // Deep sleep, a refused command, then a wake from the pin
        wr(`REG_CONTROL, 16'h0000);
        wr(`REG_COMMAND, 16'h0003);
        step();
        chk_mode(power_ctrl_pkg::MODE_GATED);
        chk_dom(16'h08a8);
        chk_bit("sysram valid", 1'b0, i_power_link_if.sysram_valid);
        wr(`REG_COMMAND, 16'h0001);
        step();
        chk_mode(power_ctrl_pkg::MODE_GATED);
        @(posedge clk);
        wake_in <= 1'b1;
        repeat (2) @(posedge clk);
        wake_in <= 1'b0;
        wait_active(n_copy, n_hold, last);
        chk_vec("copies after deep", {8'h00, `COPY_WORDS}, 16'(n_copy));
        chk_vec("last copy address", {8'h00, `COPY_WORDS - 8'h01}, {8'h00, last});
        chk_bit("sysram valid", 1'b1, i_power_link_if.sysram_valid);
        chk_dom(16'h0daf);
        // Remap, then software reset keeps it
        wr(`REG_CONTROL, 16'h0002);
        step();
        chk_bit("remap", 1'b1, boot_from_sysram);
        wr(`REG_COMMAND, 16'h0004);
        wait_active(n_copy, n_hold, last);
        chk_vec("core reset cycles", {12'h000, `RESET_CYCLES} + 16'h0001, 16'(n_hold));
        chk_bit("remap kept", 1'b1, boot_from_sysram);
        // Hardware reset in mid-run clears the sticky remap
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        step();
        chk_bit("remap after reset", 1'b0, boot_from_sysram);
        chk_dom(16'h0f87);
        rd(`REG_STATUS, d);
        chk_vec("status after reset", 16'h0018, d);
        end_of_test();
    end
endmodule
